// ===== rtl/psrc_ctl.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "psrc_regs.svh"
// Contract
// - First register writes gated by capability two
// - Second register writes gated by capability four
// - First register at 0x044, resets zero
// - Second register at 0x048, resets zero
// - Bits 9, 8 reset encoder units
// - Bits 14, 12 reset two-wire units
// - Bits 5, 4 reset sync serial units
// - Bits 2..0 reset async serial units
// - Second register bits 7..0 reset ports
// - Reserved bits read zero, ignore writes
module psrc_ctl
  import psrc_pkg::*;
(
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high writes
  input wire psrc_addr_t paddr, // APB byte address
  input wire psrc_word_t pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output psrc_word_t prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire psrc_word_t capability_mask_two, // Units present, first register
  input wire psrc_word_t capability_mask_four, // Ports present, second register
  output psrc_ctl_one_t ctl_one_resets, // Unit resets, high holds reset
  output psrc_ctl_two_t ctl_two_resets // Port resets, high holds reset
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and decode

  logic done;
  logic hit_one;
  logic hit_two;
  logic wr_one;
  logic wr_two;
  psrc_word_t wdata_eff;
  psrc_word_t reg_one_q;
  psrc_word_t reg_two_q;
  psrc_word_t rd_mux;
  logic [1:0] wait_cnt_r;

  psrc_apb_slv u_slv (
    .core_clk(core_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .done(done)
  );

  // Wait states of the current access phase, for the checks below
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt_r <= 2'h0;
    end else if (psel && penable && !pready) begin
      wait_cnt_r <= 2'(wait_cnt_r + 2'h1);
    end else begin
      wait_cnt_r <= 2'h0;
    end
  end

  assign hit_one = (paddr == `PSRC_OFF_ONE);
  assign hit_two = (paddr == `PSRC_OFF_TWO);
  assign wr_one = done && pwrite && hit_one;
  assign wr_two = done && pwrite && hit_two;

  // Unstrobed lanes keep their old contents
  always_comb begin
    wdata_eff = reg_one_q;
    if (hit_two) begin
      wdata_eff = reg_two_q;
    end
    for (int i = 0; i < 4; i++) begin
      if (pstrb[i]) begin
        wdata_eff[i*8 +: 8] = pwdata[i*8 +: 8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  psrc_mask_reg #(
    .W(32),
    .WMASK(`PSRC_WMASK_ONE),
    .RSTV(`PSRC_RST_ONE)
  ) u_reg_one (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_en(wr_one),
    .wdata(wdata_eff),
    .cap(capability_mask_two),
    .q(reg_one_q)
  );

  psrc_mask_reg #(
    .W(32),
    .WMASK(`PSRC_WMASK_TWO),
    .RSTV(`PSRC_RST_TWO)
  ) u_reg_two (
    .core_clk(core_clk),
    .rstn(rstn),
    .wr_en(wr_two),
    .wdata(wdata_eff),
    .cap(capability_mask_four),
    .q(reg_two_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data and error

  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_one) begin
      rd_mux = reg_one_q;
    end else if (hit_two) begin
      rd_mux = reg_two_q;
    end
  end

  // Captured when ready rises; the register cannot change before completion
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= rd_mux;
    end else if (done) begin
      prdata <= 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= psel && penable && !pready && !(hit_one || hit_two);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral reset lines

  // A high bit keeps the unit in reset; zero releases it
  assign ctl_one_resets.comparator2_reset = reg_one_q[`PSRC_BIT_CMP2];
  assign ctl_one_resets.comparator1_reset = reg_one_q[`PSRC_BIT_CMP1];
  assign ctl_one_resets.comparator0_reset = reg_one_q[`PSRC_BIT_CMP0];
  assign ctl_one_resets.gp_counter3_reset = reg_one_q[`PSRC_BIT_GPC3];
  assign ctl_one_resets.gp_counter2_reset = reg_one_q[`PSRC_BIT_GPC2];
  assign ctl_one_resets.gp_counter1_reset = reg_one_q[`PSRC_BIT_GPC1];
  assign ctl_one_resets.gp_counter0_reset = reg_one_q[`PSRC_BIT_GPC0];
  assign ctl_one_resets.two_wire_unit1_reset = reg_one_q[`PSRC_BIT_TWU1];
  assign ctl_one_resets.two_wire_unit0_reset = reg_one_q[`PSRC_BIT_TWU0];
  assign ctl_one_resets.encoder_unit1_reset = reg_one_q[`PSRC_BIT_ENC1];
  assign ctl_one_resets.encoder_unit0_reset = reg_one_q[`PSRC_BIT_ENC0];
  assign ctl_one_resets.sync_serial1_reset = reg_one_q[`PSRC_BIT_SYN1];
  assign ctl_one_resets.sync_serial0_reset = reg_one_q[`PSRC_BIT_SYN0];
  assign ctl_one_resets.async_serial2_reset = reg_one_q[`PSRC_BIT_ASY2];
  assign ctl_one_resets.async_serial1_reset = reg_one_q[`PSRC_BIT_ASY1];
  assign ctl_one_resets.async_serial0_reset = reg_one_q[`PSRC_BIT_ASY0];
  assign ctl_two_resets = reg_two_q[`PSRC_BIT_PORT_MSB:`PSRC_BIT_PORT_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  localparam psrc_word_t WMASK_ONE_C = `PSRC_WMASK_ONE;

  AST_ONE_MASK: assert property (
    wr_one |=> reg_one_q == ($past(wdata_eff) & $past(capability_mask_two) & `PSRC_WMASK_ONE)
  ) else $error("first register write not gated by capability");

  AST_TWO_MASK: assert property (
    wr_two |=> reg_two_q == ($past(wdata_eff) & $past(capability_mask_four) & `PSRC_WMASK_TWO)
  ) else $error("second register write not gated by capability");

  AST_ONE_READ: assert property (
    (done && !pwrite && paddr == `PSRC_OFF_ONE) |-> (prdata == reg_one_q && !pslverr)
  ) else $error("first register read wrong");

  AST_TWO_READ: assert property (
    (done && !pwrite && paddr == `PSRC_OFF_TWO) |-> (prdata == reg_two_q && !pslverr)
  ) else $error("second register read wrong");

  AST_ONE_RSV: assert property (
    (reg_one_q & ~`PSRC_WMASK_ONE) == 32'h00000000
  ) else $error("reserved bit set in first register");

  AST_TWO_RSV: assert property (
    (done && !pwrite && hit_two) |-> prdata[31:8] == 24'h000000
  ) else $error("reserved bits of second register read nonzero");

  AST_ENCODER: assert property (
    wr_one ##1 1'b1 |-> ctl_one_resets.encoder_unit1_reset == ($past(wdata_eff[9]) & $past(capability_mask_two[9]))
      && ctl_one_resets.encoder_unit0_reset == ($past(wdata_eff[8]) & $past(capability_mask_two[8]))
  ) else $error("encoder reset lines wrong");

  AST_TWO_WIRE: assert property (
    {ctl_one_resets.two_wire_unit1_reset, ctl_one_resets.two_wire_unit0_reset} == {reg_one_q[14], reg_one_q[12]}
  ) else $error("two-wire reset lines wrong");

  AST_SYNC: assert property (
    $rose(reg_one_q[5]) |-> ctl_one_resets.sync_serial1_reset && $past(wr_one)
  ) else $error("sync serial reset rose without a write");

  AST_ASYNC: assert property (
    {ctl_one_resets.async_serial2_reset, ctl_one_resets.async_serial1_reset,
     ctl_one_resets.async_serial0_reset} == reg_one_q[2:0]
  ) else $error("async serial reset lines wrong");

  AST_PORTS: assert property (
    wr_two |=> ctl_two_resets == ($past(wdata_eff[7:0]) & $past(capability_mask_four[7:0]))
  ) else $error("port reset lines wrong");

  AST_CMP_GP: assert property (
    {ctl_one_resets.comparator2_reset, ctl_one_resets.comparator1_reset, ctl_one_resets.comparator0_reset,
     ctl_one_resets.gp_counter3_reset, ctl_one_resets.gp_counter2_reset, ctl_one_resets.gp_counter1_reset,
     ctl_one_resets.gp_counter0_reset} == {reg_one_q[26:24], reg_one_q[19:16]}
  ) else $error("comparator or counter reset lines wrong");

  AST_HOLD: assert property (
    !wr_one && !wr_two |=> $stable(ctl_one_resets) && $stable(ctl_two_resets)
  ) else $error("reset line changed without a write");

  AST_READY: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready
  ) else $error("ready not a single cycle after one wait");

  AST_UNMAPPED: assert property (
    (done && !(hit_one || hit_two)) |-> pslverr && prdata == 32'h00000000
  ) else $error("unmapped access not flagged");

  AST_WAIT_BOUND: assert property (
    (wait_cnt_r <= `PSRC_WAIT_STATES)
  ) else $error("more than one wait state in an access");

  AST_WAIT_ONE: assert property (
    pready |->
      wait_cnt_r == `PSRC_WAIT_STATES
  ) else $error("ready without exactly one wait state");

  AST_READY_SRC: assert property (
    pready |->
      $past(psel && penable)
  ) else $error("ready outside an access phase");

  AST_ERR_WITH_READY: assert property (
    pslverr |->
      pready && !(hit_one || hit_two)
  ) else $error("error flag without ready or on a mapped address");

  AST_RDATA_IDLE: assert property (
    !pready |->
      prdata == 32'h00000000
  ) else $error("read data not zero outside a completing access");

  AST_RDATA_WRITE: assert property (
    (pready && pwrite) |->
      prdata == 32'h00000000
  ) else $error("read data not zero on a write");

  AST_ONE_CHANGE: assert property (
    $changed(reg_one_q) |->
      $past(wr_one)
  ) else $error("first register changed without a write");

  AST_TWO_CHANGE: assert property (
    $changed(reg_two_q) |->
      $past(wr_two)
  ) else $error("second register changed without a write");

  AST_RELEASE: assert property (
    $fell(ctl_one_resets.async_serial0_reset) |->
      $past(wr_one)
  ) else $error("unit released without a write");

  AST_ONE_DECODE: assert property (
    (done && pwrite && !hit_one) |=>
      $stable(reg_one_q)
  ) else $error("first register written at another address");

  AST_TWO_DECODE: assert property (
    (done && pwrite && !hit_two) |=>
      $stable(reg_two_q)
  ) else $error("second register written at another address");

  AST_READ_NO_WRITE: assert property (
    (done && !pwrite) |=>
      $stable(reg_one_q) && $stable(reg_two_q)
  ) else $error("register changed by a read");

  AST_ONE_LANE_KEEP: assert property (
    (wr_one && !pstrb[0]) |=>
      reg_one_q[7:0] == ($past(reg_one_q[7:0]) & $past(capability_mask_two[7:0]))
  ) else $error("unstrobed lane of first register not kept");

  AST_ONE_LANE_TAKE: assert property (
    (wr_one && pstrb[0]) |=>
      reg_one_q[7:0] == ($past(pwdata[7:0]) & $past(capability_mask_two[7:0]) & WMASK_ONE_C[7:0])
  ) else $error("strobed lane of first register not taken");

  AST_TWO_LANE_KEEP: assert property (
    (wr_two && !pstrb[0]) |=>
      reg_two_q[7:0] == ($past(reg_two_q[7:0]) & $past(capability_mask_four[7:0]))
  ) else $error("unstrobed lane of second register not kept");

  AST_ONE_ABSENT: assert property (
    wr_one |=>
      (reg_one_q & ~$past(capability_mask_two)) == 32'h00000000
  ) else $error("absent unit bit set in first register");

  AST_TWO_ABSENT: assert property (
    wr_two |=>
      (reg_two_q & ~$past(capability_mask_four)) == 32'h00000000
  ) else $error("absent port bit set in second register");

  AST_TWO_RSV_STORE: assert property (
    (reg_two_q & ~`PSRC_WMASK_TWO) == 32'h00000000
  ) else $error("reserved bit set in second register");

  AST_ONE_RSV_READ: assert property (
    (done && !pwrite && hit_one) |->
      (prdata & ~`PSRC_WMASK_ONE) == 32'h00000000
  ) else $error("reserved bits of first register read nonzero");

  AST_ENC_LINES: assert property (
    {ctl_one_resets.encoder_unit1_reset, ctl_one_resets.encoder_unit0_reset} ==
      reg_one_q[9:8]
  ) else $error("encoder reset lines do not follow bits 9 and 8");

  AST_SYNC_LINES: assert property (
    {ctl_one_resets.sync_serial1_reset, ctl_one_resets.sync_serial0_reset} ==
      reg_one_q[5:4]
  ) else $error("sync serial reset lines do not follow bits 5 and 4");

  AST_PORT_LINES: assert property (
    {ctl_two_resets.port_h_reset, ctl_two_resets.port_a_reset} ==
      {reg_two_q[7], reg_two_q[0]}
  ) else $error("port reset lines do not follow bits 7 and 0");

endmodule

// ===== common/psrc_regs.svh
`ifndef PSRC_REGS_SVH
`define PSRC_REGS_SVH

// Byte offsets from the block base
`define PSRC_OFF_ONE 12'h044
`define PSRC_OFF_TWO 12'h048

// Reset values
`define PSRC_RST_ONE 32'h00000000
`define PSRC_RST_TWO 32'h00000000

// Writable bits; every other position reads zero
`define PSRC_WMASK_ONE 32'h070F5337
`define PSRC_WMASK_TWO 32'h000000FF

// Field positions, first control register
`define PSRC_BIT_CMP2 26
`define PSRC_BIT_CMP1 25
`define PSRC_BIT_CMP0 24
`define PSRC_BIT_GPC3 19
`define PSRC_BIT_GPC2 18
`define PSRC_BIT_GPC1 17
`define PSRC_BIT_GPC0 16
`define PSRC_BIT_TWU1 14
`define PSRC_BIT_TWU0 12
`define PSRC_BIT_ENC1 9
`define PSRC_BIT_ENC0 8
`define PSRC_BIT_SYN1 5
`define PSRC_BIT_SYN0 4
`define PSRC_BIT_ASY2 2
`define PSRC_BIT_ASY1 1
`define PSRC_BIT_ASY0 0

// Field positions, second control register
`define PSRC_BIT_PORT_LSB 0
`define PSRC_BIT_PORT_MSB 7

// Wait states the slave inserts in every access phase
`define PSRC_WAIT_STATES 2'h1

`endif

// ===== common/psrc_pkg.sv
package psrc_pkg;

  typedef logic [11:0] psrc_addr_t;
  typedef logic [31:0] psrc_word_t;

  typedef struct packed {
    logic comparator2_reset;
    logic comparator1_reset;
    logic comparator0_reset;
    logic gp_counter3_reset;
    logic gp_counter2_reset;
    logic gp_counter1_reset;
    logic gp_counter0_reset;
    logic two_wire_unit1_reset;
    logic two_wire_unit0_reset;
    logic encoder_unit1_reset;
    logic encoder_unit0_reset;
    logic sync_serial1_reset;
    logic sync_serial0_reset;
    logic async_serial2_reset;
    logic async_serial1_reset;
    logic async_serial0_reset;
  } psrc_ctl_one_t;

  typedef struct packed {
    logic port_h_reset;
    logic port_g_reset;
    logic port_f_reset;
    logic port_e_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_b_reset;
    logic port_a_reset;
  } psrc_ctl_two_t;

endpackage

// ===== rtl/psrc_mask_reg.sv
`timescale 1ns/1ns
module psrc_mask_reg #(
  parameter int W = 32,
  parameter logic [W-1:0] WMASK = '1,
  parameter logic [W-1:0] RSTV = '0
) (
  input wire logic core_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic wr_en, // One-cycle write strobe
  input wire logic [W-1:0] wdata, // Byte-merged write data
  input wire logic [W-1:0] cap, // Capability mask
  output logic [W-1:0] q // Stored value
);

  // Absent units and reserved bits can never be set
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= RSTV;
    end else if (wr_en) begin
      q <= wdata & cap & WMASK;
    end
  end

endmodule

// ===== rtl/psrc_apb_slv.sv
`timescale 1ns/1ns
module psrc_apb_slv
  import psrc_pkg::*;
(
  input wire logic core_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  output logic pready, // Registered ready
  output logic done // Access completes this edge
);

  // Every access phase takes exactly two cycles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  assign done = psel && penable && pready;

endmodule

// ===== verification/psrc_ctl_test.sv
`timescale 1ns/1ns
`include "psrc_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module psrc_ctl_test;
  import psrc_pkg::*;
  localparam psrc_word_t M1 = 32'h070F5337;
  localparam psrc_word_t M2 = 32'h000000FF;
  logic core_clk = 1'b0;
  logic rstn, psel, penable, pwrite, pslverr, pready, erv;
  logic [3:0] pstrb;
  psrc_addr_t paddr, a;
  psrc_word_t pwdata, prdata, cap2, cap4, e1, e2, d, rdv;
  psrc_ctl_one_t ctl_one_resets;
  psrc_ctl_two_t ctl_two_resets;
  int n_fail = 0;
  int checks_done = 0;
  psrc_ctl psrc_ctl_inst (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capability_mask_two(cap2), .capability_mask_four(cap4), .ctl_one_resets(ctl_one_resets),
    .ctl_two_resets(ctl_two_resets));
  always #50 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  function automatic psrc_word_t merge(psrc_word_t o, psrc_word_t v, logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b+:8] = v[8*b+:8];
    return o;
  endfunction
  function automatic logic [15:0] pack1(psrc_word_t w);
    return {w[26:24], w[19:16], w[14], w[12], w[9:8], w[5:4], w[2:0]};
  endfunction
  task automatic apb(input psrc_addr_t ad, input logic w, input psrc_word_t v, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= v;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic check_all();
    apb(`PSRC_OFF_ONE, 1'b0, '0, 4'h0);
    `CHK(rdv, e1)
    `CHK(erv, 1'b0)
    apb(`PSRC_OFF_TWO, 1'b0, '0, 4'h0);
    `CHK(rdv, e2)
    `CHK(erv, 1'b0)
    @(negedge core_clk);
    `CHK(ctl_one_resets, pack1(e1))
    `CHK(ctl_two_resets, e2[7:0])
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #(100 * 20000);
    $display("unexpected at %0t: watchdog expired", $time);
    n_fail++;
    tally_and_finish();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
    cap2 = '1;
    cap4 = '1;
    e1 = '0;
    e2 = '0;
    void'($urandom(74713));
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    apb(`PSRC_OFF_ONE, 1'b0, '0, 4'h0);
    `CHK(rdv, 32'h00000000)
    apb(`PSRC_OFF_TWO, 1'b0, '0, 4'h0);
    `CHK(rdv, 32'h00000000)
    check_all();
    for (int i = 0; i < 80; i++) begin
      a = i[0] ? `PSRC_OFF_TWO : `PSRC_OFF_ONE;
      d = (i < 4) ? 32'hFFFFFFFF : $urandom;
      @(posedge core_clk);
      cap2 <= (i < 2) ? 32'hFFFFFFFF : $urandom;
      cap4 <= (i < 2) ? 32'hFFFFFFFF : $urandom;
      apb(a, 1'b1, d, (i < 40) ? 4'hF : 4'($urandom));
      `CHK(erv, 1'b0)
      if (i[0]) e2 = merge(e2, d, pstrb) & cap4 & M2;
      else e1 = merge(e1, d, pstrb) & cap2 & M1;
      cap2 <= ~cap2;
      cap4 <= ~cap4;
      check_all();
    end
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 12'h040 : (k == 1) ? 12'h04C : (k == 2) ? 12'h045 : (k == 3) ? 12'h844 : 12'h000;
      apb(a, 1'b1, 32'hFFFFFFFF, 4'hF);
      `CHK(erv, 1'b1)
      apb(a, 1'b0, '0, 4'h0);
      `CHK(rdv, 32'h00000000)
      `CHK(erv, 1'b1)
      check_all();
    end
    @(posedge core_clk);
    rstn <= 1'b0;
    @(negedge core_clk);
    `CHK(ctl_one_resets, 16'h0000)
    `CHK(ctl_two_resets, 8'h00)
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    e1 = '0;
    e2 = '0;
    check_all();
    apb(`PSRC_OFF_ONE, 1'b1, '0, 4'hF);
    apb(`PSRC_OFF_TWO, 1'b1, '0, 4'hF);
    e1 = '0;
    e2 = '0;
    check_all();
    tally_and_finish();
  end
endmodule
